// ---- verif/spxf_slave_model.sv ----
/*
  Far-side serial slave model for the master link.
  Assumes it is always selected and shares the core's clock phase.
*/
`timescale 1ns/100ps
`default_nettype none
module spxf_slave_model (
  input  wire logic       i_sck,
  input  wire logic       i_sck_oe,
  input  wire logic       i_mosi,
  input  wire logic       i_phase,
  input  wire logic       i_arm,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic [7:0]      o_rx
);
  logic [7:0] sr = 8'h00;
  int         ec = 0;
  //////////////////////////////////////////////////////////////
  // load next byte, restart edge count
  always @(i_arm) begin
    ec = 0;
    sr = i_tx;
  end
  always @(i_sck) begin
    if (i_sck_oe) begin
      ec = ec + 1;
      if (ec[0] != i_phase)
        o_rx = {o_rx[6:0], i_mosi};
      else if (ec > 1 && ec < 16)
        sr = {sr[6:0], ~sr[0]};
    end
  end
  assign o_miso = sr[7];
endmodule // spxf_slave_model
`default_nettype wire

// ---- verif/tb_top.sv ----
/*
  Self-checking bench for the serial link core.
  Assumes the slave model on the link and a 10 MHz bus clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import spxf_pkg::*;
;
  logic       i_clk   = 1'b0;
  logic       i_srst  = 1'b1;
  logic [1:0] i_addr  = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr    = 1'b0;
  logic       i_rd    = 1'b0;
  logic       i_ss_n  = 1'b1;
  logic       i_sck   = 1'b0;
  logic       i_mosi  = 1'b0;
  logic       phase   = 1'b0;
  logic       arm     = 1'b0;
  logic       pend    = 1'b0;
  logic [7:0] ptx     = 8'h00;
  logic [7:0] rdata, prx;
  logic       sck, sck_oe, mosi, miso, miso_oe, err_req, rx_req, tx_req;
  logic       smiso, mosi_oe;
  logic [7:0] expq[$];
  int         fails = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         edges = 0;
  int         seed = 59346;

  always #50 i_clk = ~i_clk;

  spxf_core spxf_core_i (
    .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_sck(i_sck),
    .i_ss_n(i_ss_n), .i_mosi(i_mosi), .i_miso(miso), .o_sck(sck),
    .o_sck_oe(sck_oe), .o_mosi(mosi), .o_mosi_oe(mosi_oe), .o_miso(smiso),
    .o_miso_oe(miso_oe), .o_err_req(err_req), .o_rx_req(rx_req),
    .o_tx_req(tx_req)
  );
  spxf_slave_model spxf_slave_model_i (
    .i_sck(sck), .i_sck_oe(sck_oe), .i_mosi(mosi), .i_phase(phase),
    .i_arm(arm), .i_tx(ptx), .o_miso(miso), .o_rx(prx)
  );
  //////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    expq.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic xfer(input logic [7:0] d, input logic [7:0] p,
                      input logic [1:0] r);
    int n;
    n = 2;
    edges = 0;
    ptx <= p;
    arm <= ~arm;
    wr(SPXF_ADDR_DATA, d);
    while (edges == 0 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    chk("start", 8'h01, {7'h00, n <= 3 * (1 << 2 * r) + 3});
    while (edges < 16 && n < 4000) begin
      @(posedge i_clk);
      n++;
    end
    repeat ((2 << 2 * r) + 4) @(posedge i_clk);
    chk("edges", 8'h10, edges[7:0]);
  endtask

  // bench as far master: 16 clock changes, data out on drive edges
  task automatic slv(input logic ph, input logic [7:0] mo,
                     input logic [7:0] mi);
    logic [7:0] got;
    got = 8'h00;
    wr(SPXF_ADDR_DATA, mi);
    i_ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      i_mosi <= mo[i];
      if (ph) i_sck <= 1'b1;
      repeat (4) @(posedge i_clk);
      got = {got[6:0], smiso};
      i_sck <= !ph;
      repeat (4) @(posedge i_clk);
      if (!ph) i_sck <= 1'b0;
    end
    repeat (4) @(posedge i_clk);
    chk("miso", mi, got);
    rd(SPXF_ADDR_STAT, 8'hCC);
    rd(SPXF_ADDR_DATA, mo);
  endtask
  //////////////////////////////////////////////////////////////
  // serial clock edges while driven
  always @(sck) if (sck_oe) edges = edges + 1;

  // read results, oldest note first; run limit
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    pend <= i_rd;
    if (pend)
      chk("rdata", expq.pop_front(), rdata);
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    logic [7:0] t, u, v, w;
    logic [5:0] b;
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    rd(SPXF_ADDR_CTRL, 8'h28);
    rd(SPXF_ADDR_STAT, 8'h08);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    rd(SPXF_ADDR_CTRL, 8'h28);
    chk("sck_oe", 8'h00, {7'h00, sck_oe});
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      b = {3'h5, m[1], m[0], 1'b0};
      t = $random(seed);
      u = $random(seed);
      phase <= m[0];
      wr(SPXF_ADDR_CTRL, {b, 2'h1});
      wr(SPXF_ADDR_STAT, {6'h00, m[1:0]});
      wr(SPXF_ADDR_CTRL, {b, 2'h3});
      @(negedge i_clk);
      chk("sck_oe", 8'h01, {7'h00, sck_oe});
      chk("idle", {7'h00, m[1]}, {7'h00, sck});
      chk("tx_req", 8'h01, {7'h00, tx_req});
      chk("mosi_oe", 8'h01, {7'h00, mosi_oe});
      @(posedge i_clk);
      xfer(t, u, m[1:0]);
      chk("tx_req", 8'h00, {7'h00, tx_req});
      chk("rx_req", 8'h01, {7'h00, rx_req});
      chk("prx", t, prx);
      rd(SPXF_ADDR_CTRL, {b, 2'h2});
      rd(SPXF_ADDR_STAT, {6'h22, m[1:0]});
      rd(SPXF_ADDR_DATA, u);
      rd(SPXF_ADDR_STAT, {6'h02, m[1:0]});
      wr(SPXF_ADDR_CTRL, {b, 2'h0});
    end
    $display("test modes done");
    t = $random(seed);
    u = $random(seed);
    v = $random(seed);
    w = $random(seed);
    phase <= 1'b1;
    wr(SPXF_ADDR_STAT, 8'h40);
    wr(SPXF_ADDR_CTRL, 8'h2A);
    xfer(t, u, 2'h0);
    chk("err_req", 8'h00, {7'h00, err_req});
    xfer(v, w, 2'h0);
    chk("err_req", 8'h01, {7'h00, err_req});
    rd(SPXF_ADDR_STAT, 8'hE8);
    rd(SPXF_ADDR_DATA, u);
    rd(SPXF_ADDR_STAT, 8'h48);
    $display("test overflow done");
    i_ss_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(SPXF_ADDR_STAT, 8'h48);
    wr(SPXF_ADDR_STAT, 8'h44);
    repeat (2) @(posedge i_clk);
    rd(SPXF_ADDR_STAT, 8'h5C);
    wr(SPXF_ADDR_CTRL, 8'h2A);
    rd(SPXF_ADDR_STAT, 8'h5C);
    i_ss_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk("err_req", 8'h01, {7'h00, err_req});
    rd(SPXF_ADDR_STAT, 8'h5C);
    wr(SPXF_ADDR_CTRL, 8'h2A);
    rd(SPXF_ADDR_STAT, 8'h4C);
    chk("err_req", 8'h00, {7'h00, err_req});
    $display("test fault done");
    wr(SPXF_ADDR_CTRL, 8'h08);
    wr(SPXF_ADDR_CTRL, 8'h0A);
    chk("mosi_oe", 8'h00, {7'h00, mosi_oe});
    repeat (2) @(posedge i_clk);
    chk("miso_oe", 8'h00, {7'h00, miso_oe});
    i_ss_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    chk("miso_oe", 8'h01, {7'h00, miso_oe});
    i_ss_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("miso_oe", 8'h00, {7'h00, miso_oe});
    rd(SPXF_ADDR_STAT, 8'h4C);
    $display("test select done");
    t = $random(seed);
    u = $random(seed);
    v = $random(seed);
    w = $random(seed);
    slv(1'b1, t, u);
    slv(1'b1, v, w);
    // select high again before the next byte
    i_ss_n <= 1'b1;
    wr(SPXF_ADDR_CTRL, 8'h00);
    wr(SPXF_ADDR_CTRL, 8'h02);
    slv(1'b0, w, v);
    i_ss_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    rd(SPXF_ADDR_STAT, 8'h4C);
    $display("test slave done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire

// ---- verilog/spxf_core.sv ----
/*
  Serial link shift engine with registers, flags and error request.
  Assumes pins synchronous to i_clk and a one-cycle strobe register port.
*/
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module spxf_core
  import spxf_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  input  wire logic       i_sck,
  input  wire logic       i_ss_n,
  input  wire logic       i_mosi,
  input  wire logic       i_miso,
  output logic            o_sck,
  output logic            o_sck_oe,
  output logic            o_mosi,
  output logic            o_mosi_oe,
  output logic            o_miso,
  output logic            o_miso_oe,
  output logic            o_err_req,
  output logic            o_rx_req,
  output logic            o_tx_req
);
  spxf_ctrl_s  ctrl, next_ctrl;
  spxf_cfg_s   cfg, next_cfg;
  spxf_state_e state, next_state;
  logic rf, ovf, mode_fault_flag, tx_empty, rf_arm, mode_fault_flag_arm, discard, lvl;
  logic next_rf, next_ovf, next_mode_fault_flag, next_tx_empty;
  logic next_rf_arm, next_mode_fault_flag_arm, next_discard, next_lvl;
  logic [7:0] tx_buf, rx_buf, out_sr, in_sr;
  logic [7:0] next_tx_buf, next_rx_buf, next_out_sr, next_in_sr;
  logic [4:0] cnt, next_cnt, k;
  logic ss_q, sck_q, tick;
  logic mst, en, sel, edge_ev, smp, fault_now, bit_in, busy;
  logic [7:0] next_rdata;

  assign mst  = ctrl.master_select_bit;
  assign en   = ctrl.link_enable_bit;
  assign sel  = !i_ss_n;
  assign busy = (state == SPXF_RUN);

  spxf_rate_div u_div (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_run  (en && mst),
    .i_rate (cfg.clock_rate_select),
    .o_tick (tick)
  );

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_ctrl     = ctrl;
    next_cfg      = cfg;
    next_state    = state;
    next_rf       = rf;
    next_ovf      = ovf;
    next_mode_fault_flag     = mode_fault_flag;
    next_tx_empty = tx_empty;
    next_rf_arm   = rf_arm;
    next_mode_fault_flag_arm = mode_fault_flag_arm;
    next_discard  = discard;
    next_lvl      = lvl;
    next_tx_buf   = tx_buf;
    next_rx_buf   = rx_buf;
    next_out_sr   = out_sr;
    next_in_sr    = in_sr;
    next_cnt      = cnt;
    k             = cnt + 5'h01;
    smp           = 1'b0;
    bit_in        = mst ? i_miso : i_mosi;
    edge_ev       = mst ? tick : ((sck_q ^ i_sck) && sel);
    fault_now = en && (mst ? sel : (busy && !sel));

    // bus side effects, clears first so later sets win
    if (i_rd && i_addr == SPXF_ADDR_STAT) begin
      next_rf_arm   = rf || ovf;
      next_mode_fault_flag_arm = mode_fault_flag;
    end
    if (i_rd && i_addr == SPXF_ADDR_DATA && rf_arm) begin
      next_rf     = 1'b0;
      next_ovf    = 1'b0;
      next_rf_arm = 1'b0;
    end
    if (i_wr && i_addr == SPXF_ADDR_CTRL) begin
      next_ctrl      = spxf_ctrl_s'(i_wdata);
      next_ctrl.rsv6 = 1'b0;
      next_ctrl.rsv2 = 1'b0;
      if (mode_fault_flag_arm && !fault_now) begin
        next_mode_fault_flag = 1'b0;
      end
      next_mode_fault_flag_arm = 1'b0;
    end
    if (i_wr && i_addr == SPXF_ADDR_STAT) begin
      next_cfg = spxf_cfg_s'({i_wdata[6], i_wdata[2:0]});
    end
    if (i_wr && i_addr == SPXF_ADDR_DATA) begin
      next_tx_buf   = i_wdata;
      next_tx_empty = 1'b0;
      next_ctrl.transmit_irq_enable = 1'b0;
    end

    unique case (state)
      SPXF_IDLE: begin
        next_lvl = 1'b0;
        // master starts on next divider tick
        if (mst && tick && !tx_empty) begin
          next_state    = SPXF_RUN;
          next_out_sr   = tx_buf;
          next_tx_empty = 1'b1;
          next_cnt      = 5'h00;
        // select fall starts phase zero slave
        end else if (!mst && !ctrl.clock_phase_bit && ss_q && sel) begin
          next_state = SPXF_RUN;
          next_cnt   = 5'h00;
          if (!tx_empty) begin
            next_out_sr   = tx_buf;
            next_tx_empty = 1'b1;
          end
        // first clock edge starts phase one slave
        // select may stay low between bytes
        end else if (!mst && ctrl.clock_phase_bit && edge_ev) begin
          next_state = SPXF_RUN;
          next_cnt   = 5'h01;
          if (!tx_empty) begin
            next_out_sr   = tx_buf;
            next_tx_empty = 1'b1;
          end
        end
      end
      SPXF_RUN: begin
        if (edge_ev) begin
          // phase zero first half idle, phase one edge first
          next_lvl = !lvl;
          next_cnt = k;
          smp      = ctrl.clock_phase_bit ? !k[0] : k[0];
          if (smp) begin
            next_in_sr = {in_sr[6:0], bit_in};
            if (k <= 5'h02) begin
              next_discard = rf;
              if (rf) begin
                next_ovf = 1'b1;
              end
            end
          end else if (k != 5'h01) begin
            next_out_sr = {out_sr[6:0], 1'b0};
          end
          if (k == SPXF_EDGES) begin
            next_state = SPXF_IDLE;
            if (!next_discard) begin
              next_rx_buf = next_in_sr;
              next_rf     = 1'b1;
            end
          end
        end
        if (!mst && !sel) begin
          next_state = SPXF_IDLE;
        end
      end
    endcase

    if (fault_now && cfg.mode_fault_enable) begin
      next_mode_fault_flag = 1'b1;
      if (mst) begin
        next_state = SPXF_IDLE;
      end
    end
    if (!en) begin
      next_state    = SPXF_IDLE;
      next_tx_empty = 1'b1;
      next_lvl      = 1'b0;
      next_cnt      = 5'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl     <= SPXF_CTRL_RST;
      cfg      <= SPXF_CFG_RST;
      state    <= SPXF_IDLE;
      rf       <= 1'b0;
      ovf      <= 1'b0;
      mode_fault_flag     <= 1'b0;
      tx_empty <= 1'b1;
      rf_arm   <= 1'b0;
      mode_fault_flag_arm <= 1'b0;
      discard  <= 1'b0;
      lvl      <= 1'b0;
      tx_buf   <= 8'h00;
      rx_buf   <= 8'h00;
      out_sr   <= 8'h00;
      in_sr    <= 8'h00;
      cnt      <= 5'h00;
      ss_q     <= 1'b1;
      sck_q    <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      cfg      <= next_cfg;
      state    <= next_state;
      rf       <= next_rf;
      ovf      <= next_ovf;
      mode_fault_flag     <= next_mode_fault_flag;
      tx_empty <= next_tx_empty;
      rf_arm   <= next_rf_arm;
      mode_fault_flag_arm <= next_mode_fault_flag_arm;
      discard  <= next_discard;
      lvl      <= next_lvl;
      tx_buf   <= next_tx_buf;
      rx_buf   <= next_rx_buf;
      out_sr   <= next_out_sr;
      in_sr    <= next_in_sr;
      cnt      <= next_cnt;
      ss_q     <= i_ss_n;
      sck_q    <= i_sck;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read data and pins
  always_comb begin
    next_rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        SPXF_ADDR_CTRL: next_rdata = ctrl;
        SPXF_ADDR_STAT: next_rdata = {rf, cfg.error_irq_enable, ovf, mode_fault_flag,
                                      tx_empty, cfg.mode_fault_enable,
                                      cfg.clock_rate_select};
        SPXF_ADDR_DATA: next_rdata = rx_buf;
        default:        next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata   <= 8'h00;
      o_sck     <= 1'b0;
      o_sck_oe  <= 1'b0;
      o_mosi    <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_miso    <= 1'b0;
      o_miso_oe <= 1'b0;
      o_err_req <= 1'b0;
      o_rx_req  <= 1'b0;
      o_tx_req  <= 1'b0;
    end else begin
      o_rdata   <= next_rdata;
      o_sck     <= next_ctrl.clock_polarity_bit ^ next_lvl;
      // clock driven only as enabled master
      o_sck_oe  <= next_ctrl.link_enable_bit && next_ctrl.master_select_bit;
      o_mosi    <= next_out_sr[7];
      o_mosi_oe <= next_ctrl.link_enable_bit && next_ctrl.master_select_bit;
      o_miso    <= next_out_sr[7];
      o_miso_oe <= next_ctrl.link_enable_bit &&
                   !next_ctrl.master_select_bit && sel;
      o_err_req <= next_cfg.error_irq_enable && (next_ovf || next_mode_fault_flag);
      o_rx_req  <= next_ctrl.rx_irq_enable && next_rf &&
                   next_ctrl.link_enable_bit;
      o_tx_req  <= next_ctrl.transmit_irq_enable && next_tx_empty;
    end
  end

  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  chk_mode_fault_flag_gate: assert property (
    $rose(mode_fault_flag) |-> $past(cfg.mode_fault_enable))
    else $error("mode fault set while disabled");
  chk_miso_sel: assert property (
    o_miso_oe |-> (en && !mst && $past(sel)))
    else $error("data out driven while not selected");
  chk_err_share: assert property (
    o_err_req == (cfg.error_irq_enable && (ovf || mode_fault_flag)))
    else $error("error request mismatch");
  chk_start_fast: assert property (
    (i_wr && i_addr == SPXF_ADDR_DATA && mst && en && !busy && tx_empty &&
     cfg.clock_rate_select == 2'h0 && !sel) |-> ##[1:2] busy)
    else $error("slow start at fastest rate");
  chk_start_slow: assert property (
    (i_wr && i_addr == SPXF_ADDR_DATA && mst && en && !busy && tx_empty &&
     !sel) |-> ##[1:128] busy)
    else $error("start later than one bit time");
  chk_ovf_keep: assert property (
    (ovf && $fell(busy)) |-> $stable(rx_buf))
    else $error("overflow replaced unread data");
  chk_rf_clear: assert property (
    $fell(rf) |-> $past(i_rd && i_addr == SPXF_ADDR_DATA && rf_arm))
    else $error("receive full cleared without sequence");
  chk_txie_drop: assert property (
    (i_wr && i_addr == SPXF_ADDR_DATA) |=> !ctrl.transmit_irq_enable)
    else $error("tx enable survived data write");
  chk_mode_fault_flag_clear: assert property (
    $fell(mode_fault_flag) |-> $past(i_wr && i_addr == SPXF_ADDR_CTRL && mode_fault_flag_arm))
    else $error("mode fault cleared without sequence");
  chk_mstr_ss: assert property (
    (mst && en && sel && cfg.mode_fault_enable) |=> mode_fault_flag)
    else $error("master select fault missed");
  chk_sck_idle: assert property (
    (!busy && !$past(busy) && $stable(ctrl)) |=>
      o_sck == ctrl.clock_polarity_bit)
    else $error("clock not at idle level");

  cov_master_xfer: cover property ($fell(busy) && mst ##1 rf);
  cov_overflow: cover property ($rose(ovf));
  cov_slave_fault: cover property (!mst && $rose(mode_fault_flag));
endmodule // spxf_core
`default_nettype wire

// ---- verilog/spxf_pkg.sv ----
/*
  Constants, register layouts and types for the serial link block.
  Assumes a single bus clock and a plain strobe register port.
*/
// Contract
// - two control bits pick one of four serial clock configurations
// - polarity bit only inverts the serial clock level
// - both ends use the same phase and polarity settings
// - slave drives its data output only while select is low
// - phase zero: first edge captures msb, select fall starts transfer
// - phase one: first clock edge drives data and starts transfer
// - phase one: slave accepts select held low across bytes
// - master starts on data write, delay independent of phase
// - phase zero idles first half period, phase one starts on edge
// - master clock free-running divider, on only with enable and master
// - master clock edges fall mid low phase of bus clock; here they change on the bus clock rising edge
// - master start within one bit time of data write
// - overflow set at first capture if unread data, new byte lost
// - overflow and mode fault share one error request enable
// - mode fault never set while its enable bit is low
// - mode fault set when select level contradicts the role
// - enabled overflow request can wake the processor
// - receive full cleared by status then data read
// - mode fault cleared by status read then control write
package spxf_pkg;

  localparam logic [1:0] SPXF_ADDR_CTRL = 2'h0;
  localparam logic [1:0] SPXF_ADDR_STAT = 2'h1;
  localparam logic [1:0] SPXF_ADDR_DATA = 2'h2;
  localparam logic [4:0] SPXF_EDGES     = 5'h10;

  typedef struct packed {
    logic rx_irq_enable;
    logic rsv6;
    logic master_select_bit;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic rsv2;
    logic link_enable_bit;
    logic transmit_irq_enable;
  } spxf_ctrl_s;

  typedef struct packed {
    logic       error_irq_enable;
    logic       mode_fault_enable;
    logic [1:0] clock_rate_select;
  } spxf_cfg_s;

  localparam spxf_ctrl_s SPXF_CTRL_RST = 8'h28;
  localparam spxf_cfg_s  SPXF_CFG_RST  = 4'h0;

  typedef enum logic {SPXF_IDLE, SPXF_RUN} spxf_state_e;

  // half a serial bit in bus cycles: rates 1, 4, 16, 64
  function automatic logic [6:0] spxf_half(input logic [1:0] rate);
    spxf_half = 7'h01 << {rate, 1'b0};
  endfunction

endpackage

// ---- verilog/spxf_rate_div.sv ----
/*
  Free-running serial clock divider for the master role.
  Assumes rate changes only while the link is disabled.
*/
`timescale 1ns/100ps
`default_nettype none
module spxf_rate_div
  import spxf_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_run,
  input  wire logic [1:0] i_rate,
  output logic            o_tick
);
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic       next_tick;

  always_comb begin
    next_cnt  = 7'h00;
    next_tick = 1'b0;
    if (i_run) begin
      if (cnt + 7'h01 >= spxf_half(i_rate)) begin
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt    <= 7'h00;
      o_tick <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule // spxf_rate_div
`default_nettype wire
